//--- hw/uiid_pkg.sv
// Summary of operation
// - read-only ident register per port, C2h/D2h
// - reads give ident, writes go FIFO control
// - bits 7:6 read 00 off, 11 on
// - pending code sits in bits 3:1
// - only highest priority enabled source reported
// - lower code shown once higher is serviced
// - line status code 011, highest priority
// - receive data or trigger code 010, second
// - character time-out code 110, third
// - transmit empty code 001, fourth
// - modem status code 000, lowest
// - source counts only when its enable set
// - any receive error raises line status
package uiid_pkg;
  localparam int NCH = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int WORD_W = 10;
  localparam int IER_W = 4;
  localparam int NSRC = 5;
  // printed offsets are register indices; byte address is index * 4
  localparam logic [NCH-1:0][7:0] IDX_IER = {8'hd1, 8'hc1};
  localparam logic [NCH-1:0][7:0] IDX_IIR = {8'hd2, 8'hc2};
  localparam logic [7:0] IDX_STAT = 8'he0;
  localparam logic [7:0] IDX_MASK = 8'he1;
  // pending source positions
  localparam int SRC_LS = 0;
  localparam int SRC_RX = 1;
  localparam int SRC_TO = 2;
  localparam int SRC_TX = 3;
  localparam int SRC_MS = 4;
  // enable register bits
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  // fifo control bits
  localparam int FCTL_FEN = 0;
  localparam int FCTL_CLRTX = 1;
  localparam int FCTL_CLRRX = 2;
  localparam int FCTL_TRIG_LO = 6;
  localparam int FCTL_TRIG_HI = 7;
  // ident register fields
  localparam int FIFO_STATE_FIELD_LO = 6;
  localparam int FIFO_STATE_FIELD_HI = 7;
  localparam int RSVD_LO = 4;
  localparam int RSVD_HI = 5;
  localparam int CODE_LO = 1;
  localparam int CODE_HI = 3;
  localparam int NOPEND_BIT = 0;
  localparam logic [1:0] FIFO_STATE_FIELD_ON = 2'h3;
  localparam logic [1:0] FIFO_STATE_FIELD_OFF = 2'h0;
  localparam logic [1:0] RSVD_VAL = 2'h0;
  localparam logic [2:0] CODE_LS = 3'h3;
  localparam logic [2:0] CODE_RX = 3'h2;
  localparam logic [2:0] CODE_TO = 3'h6;
  localparam logic [2:0] CODE_TX = 3'h1;
  localparam logic [2:0] CODE_MS = 3'h0;
  localparam logic [2:0] CODE_NONE = 3'h0;
  // reset values
  localparam logic [IER_W-1:0] IER_RST = 4'h0;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic FEN_RST = 1'b0;
  localparam logic NOPEND_RST = 1'b1;
endpackage : uiid_pkg

//--- hw/uiid_prio.sv
module uiid_prio
  import uiid_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  uiid_src_if.prio sif
);
  typedef struct packed {
    logic [2:0] code;
    logic no_pend;
  } uiid_prio_st_t;

  localparam uiid_prio_st_t ST_RST = '{code: CODE_NONE, no_pend: NOPEND_RST};

  uiid_prio_st_t st_r;
  uiid_prio_st_t st_nxt;
  logic en_ls;
  logic en_rx;
  logic en_to;
  logic en_tx;
  logic en_ms;

  // receive enable also gates the time-out source
  assign en_ls = sif.ier[IER_LS] & sif.src[SRC_LS];
  assign en_rx = sif.ier[IER_RX] & sif.src[SRC_RX];
  assign en_to = sif.ier[IER_RX] & sif.src[SRC_TO];
  assign en_tx = sif.ier[IER_TX] & sif.src[SRC_TX];
  assign en_ms = sif.ier[IER_MS] & sif.src[SRC_MS];

  // re-evaluated every cycle, so a source stays until its condition drops
  always_comb
  begin
    st_nxt = ST_RST;
    if (en_ls)
      st_nxt = '{code: CODE_LS, no_pend: 1'b0};
    else if (en_rx)
      st_nxt = '{code: CODE_RX, no_pend: 1'b0};
    else if (en_to)
      st_nxt = '{code: CODE_TO, no_pend: 1'b0};
    else if (en_tx)
      st_nxt = '{code: CODE_TX, no_pend: 1'b0};
    else if (en_ms)
      st_nxt = '{code: CODE_MS, no_pend: 1'b0};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= ST_RST;
    else
      st_r <= st_nxt;
  end

  assign sif.code = st_r.code;
  assign sif.no_pend = st_r.no_pend;

  ls_highest_a: assert property (@(posedge pclk) disable iff (!presetn)
    en_ls |=> (sif.code == CODE_LS) && !sif.no_pend)
    else $error("line status not reported first");
  rx_second_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en_rx && !en_ls) |=> (sif.code == CODE_RX) && !sif.no_pend)
    else $error("receive data code wrong");
  to_third_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en_to && !en_ls && !en_rx) |=> sif.code == CODE_TO)
    else $error("time-out code wrong");
  tx_fourth_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en_tx && !(en_ls || en_rx || en_to)) |=> sif.code == CODE_TX)
    else $error("transmit empty code wrong");
  ms_lowest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en_ms && !(en_ls || en_rx || en_to || en_tx))
      |=> (sif.code == CODE_MS) && !sif.no_pend)
    else $error("modem status code wrong");
  lower_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en_ls && en_tx) [*2] |=> sif.code != CODE_TX)
    else $error("lower source shown while higher pending");
  idle_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(en_ls || en_rx || en_to || en_tx || en_ms) |=> sif.no_pend)
    else $error("pending flag without enabled source");
  masked_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sif.src[SRC_TO] && !sif.ier[IER_RX]) |=> sif.code != CODE_TO)
    else $error("disabled time-out reported");
endmodule : uiid_prio

//--- hw/uiid_src_if.sv
interface uiid_src_if;
  import uiid_pkg::*;
  logic [NSRC-1:0] src;
  logic [IER_W-1:0] ier;
  logic [2:0] code;
  logic no_pend;
  modport prio
  (
    input src,
    input ier,
    output code,
    output no_pend
  );
  modport top
  (
    output src,
    output ier,
    input code,
    input no_pend
  );
endinterface : uiid_src_if

//--- hw/uiid_top.sv
// Design decision made here: the APB register port.
module uiid_top
  import uiid_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] ls_parity_err,
  input wire logic [NCH-1:0] ls_framing_err,
  input wire logic [NCH-1:0] ls_overrun,
  input wire logic [NCH-1:0] ls_break,
  input wire logic [NCH-1:0] rx_data_ready,
  input wire logic [NCH-1:0] rx_timeout,
  input wire logic [NCH-1:0] tx_empty,
  input wire logic [NCH-1:0] modem_change,
  output logic [NCH-1:0] fifo_enable,
  output logic [NCH-1:0][1:0] rx_trig_level,
  output logic [NCH-1:0] clr_rx_fifo,
  output logic [NCH-1:0] clr_tx_fifo,
  output logic irq
);
  typedef struct packed {
    logic [NCH-1:0][IER_W-1:0] ier;
    logic [NCH-1:0] fen;
    logic [NCH-1:0][1:0] trig;
    logic [NCH-1:0] clr_rx;
    logic [NCH-1:0] clr_tx;
    logic [NCH-1:0] stat;
    logic [NCH-1:0] mask;
    logic [NCH-1:0] pend_prev;
    logic [DATA_W-1:0] rdata;
    logic err;
  } uiid_top_st_t;

  localparam uiid_top_st_t ST_RST = '{
    ier: {NCH{IER_RST}},
    fen: {NCH{FEN_RST}},
    trig: {NCH{TRIG_RST}},
    clr_rx: '0,
    clr_tx: '0,
    stat: '0,
    mask: '0,
    pend_prev: '0,
    rdata: '0,
    err: 1'b0
  };

  uiid_top_st_t st_r;
  uiid_top_st_t st_nxt;

  logic setup;
  logic wr;
  logic aligned;
  logic [WORD_W-1:0] word;
  logic [NCH-1:0] hit_ier;
  logic [NCH-1:0] hit_iir;
  logic hit_stat;
  logic hit_mask;
  logic hit_any;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] ev;
  logic [NCH-1:0] no_pend_w;
  logic [NCH-1:0][2:0] code_w;
  logic [NCH-1:0][7:0] iir_val;

  uiid_src_if sif [NCH] ();

  // bus decode; a write lands at the access edge, read data is
  // captured at the setup edge so prdata is a flop in the access cycle
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign word = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_stat = aligned & (word == {2'h0, IDX_STAT});
  assign hit_mask = aligned & (word == {2'h0, IDX_MASK});
  assign hit_any = (|hit_ier) | (|hit_iir) | hit_stat | hit_mask;

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      assign hit_ier[c] = aligned & (word == {2'h0, IDX_IER[c]});
      // one address, read gives ident and write gives fifo control
      assign hit_iir[c] = aligned & (word == {2'h0, IDX_IIR[c]});

      // any receive error raises the line status source
      assign sif[c].src[SRC_LS] = ls_parity_err[c] | ls_framing_err[c] |
        ls_overrun[c] | ls_break[c];
      assign sif[c].src[SRC_RX] = rx_data_ready[c];
      assign sif[c].src[SRC_TO] = rx_timeout[c];
      assign sif[c].src[SRC_TX] = tx_empty[c];
      assign sif[c].src[SRC_MS] = modem_change[c];
      assign sif[c].ier = st_r.ier[c];

      assign code_w[c] = sif[c].code;
      assign no_pend_w[c] = sif[c].no_pend;
      assign pend[c] = ~sif[c].no_pend;

      assign iir_val[c] = {
        st_r.fen[c] ? FIFO_STATE_FIELD_ON : FIFO_STATE_FIELD_OFF,
        RSVD_VAL,
        code_w[c],
        no_pend_w[c]
      };

      uiid_prio u_uiid_prio
      (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif[c])
      );
    end
  endgenerate

  // a channel going from idle to pending is the interrupt event
  assign ev = pend & ~st_r.pend_prev;

  always_comb
  begin
    logic [NCH-1:0] clr;
    clr = '0;
    st_nxt = st_r;
    st_nxt.clr_rx = '0;
    st_nxt.clr_tx = '0;
    st_nxt.pend_prev = pend;
    for (int i = 0; i < NCH; i++)
    begin
      if (wr && hit_ier[i])
        st_nxt.ier[i] = pwdata[IER_W-1:0];
      if (wr && hit_iir[i])
      begin
        st_nxt.fen[i] = pwdata[FCTL_FEN];
        st_nxt.trig[i] = pwdata[FCTL_TRIG_HI:FCTL_TRIG_LO];
        // fifo clears only act when the same write sets the fifo enable bit
        st_nxt.clr_rx[i] = pwdata[FCTL_CLRRX] & pwdata[FCTL_FEN];
        st_nxt.clr_tx[i] = pwdata[FCTL_CLRTX] & pwdata[FCTL_FEN];
      end
    end
    if (wr && hit_mask)
      st_nxt.mask = pwdata[NCH-1:0];
    if (wr && hit_stat)
      clr = pwdata[NCH-1:0];
    // a new event wins over a clear in the same cycle
    st_nxt.stat = (st_r.stat & ~clr) | ev;
    if (setup)
    begin
      st_nxt.err = ~hit_any;
      st_nxt.rdata = '0;
      if (!pwrite)
      begin
        for (int i = 0; i < NCH; i++)
        begin
          if (hit_ier[i])
            st_nxt.rdata[IER_W-1:0] = st_r.ier[i];
          if (hit_iir[i])
            st_nxt.rdata[7:0] = iir_val[i];
        end
        if (hit_stat)
          st_nxt.rdata[NCH-1:0] = st_r.stat;
        if (hit_mask)
          st_nxt.rdata[NCH-1:0] = st_r.mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= ST_RST;
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & st_r.err;
  assign fifo_enable = st_r.fen;
  assign rx_trig_level = st_r.trig;
  assign clr_rx_fifo = st_r.clr_rx;
  assign clr_tx_fifo = st_r.clr_tx;
  assign irq = |(st_r.stat & st_r.mask);

  fifo_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_iir[0])
      |=> prdata[FIFO_STATE_FIELD_HI:FIFO_STATE_FIELD_LO] == {2{$past(st_r.fen[0])}})
    else $error("fifo state field wrong");
  code_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_iir[1])
      |=> prdata[CODE_HI:CODE_LO] == $past(code_w[1]) &&
          prdata[NOPEND_BIT] == $past(no_pend_w[1]))
    else $error("ident code not in bits 3:1");
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && (|hit_iir))
      |=> prdata[RSVD_HI:RSVD_LO] == RSVD_VAL && prdata[DATA_W-1:8] == '0)
    else $error("reserved ident bits not zero");
  shared_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_iir[1]) |=> fifo_enable[1] == $past(pwdata[FCTL_FEN]))
    else $error("write to ident address missed fifo control");
  err_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_break[0] && st_r.ier[0][IER_LS]) |=> !no_pend_w[0])
    else $error("receive error did not raise line status");
  sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev[0] |=> st_r.stat[0] [*2])
    else $error("event lost against clear");
  bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit_any) |=> pslverr == penable)
    else $error("unmapped access not flagged");
endmodule : uiid_top

//--- tb/uiid_host.sv
module uiid_host
  import uiid_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    hung = 1'b0;
  end
  // one apb transfer, request held until pready is seen high
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
    output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 64)
    begin
      n++;
      @(posedge pclk);
    end
    hung = (n >= 64);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : uiid_host

//--- tb/uiid_top_tb.sv
module uiid_top_tb;
  import uiid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, q;
  logic [NCH-1:0] pe = '0, fe = '0, ov = '0, bk = '0;
  logic [NCH-1:0] rdy = '0, tmo = '0, txe = '0, mdm = '0;
  logic er;
  logic [NCH-1:0] fen_o;
  logic [NCH-1:0] crx;
  logic [NCH-1:0] ctx;
  logic [NCH-1:0][1:0] trg;
  int n_fail = 0;
  int samples_checked = 0;
  always #10 pclk = ~pclk;
  uiid_top u_uiid_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ls_parity_err(pe), .ls_framing_err(fe), .ls_overrun(ov),
    .ls_break(bk), .rx_data_ready(rdy), .rx_timeout(tmo),
    .tx_empty(txe), .modem_change(mdm), .fifo_enable(fen_o),
    .rx_trig_level(trg), .clr_rx_fifo(crx), .clr_tx_fifo(ctx),
    .irq(irq));
  uiid_host u_uiid_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    u_uiid_host.xfer(w, ad(i), d, q, er);
    if (u_uiid_host.hung)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask : bus
  function automatic logic [7:0] exp_id(input logic fen,
    input logic [3:0] ie, input logic [4:0] s);
    logic [4:0] a;
    logic [2:0] c;
    a = s & {ie[IER_MS], ie[IER_TX], ie[IER_RX], ie[IER_RX], ie[IER_LS]};
    c = a[SRC_LS] ? CODE_LS : a[SRC_RX] ? CODE_RX : a[SRC_TO] ? CODE_TO :
      a[SRC_TX] ? CODE_TX : CODE_MS;
    return {fen ? FIFO_STATE_FIELD_ON : FIFO_STATE_FIELD_OFF, RSVD_VAL, (|a) ? c : CODE_NONE, ~|a};
  endfunction : exp_id
  // configure one channel, drive its sources, read back its ident byte
  task automatic run(input int ch, input logic fen, input logic [3:0] ie,
    input logic [3:0] e, input logic [3:0] o);
    logic [1:0] tr;
    logic [1:0] cl;
    tr = 2'($urandom);
    cl = 2'($urandom);
    bus(1'b1, IDX_IER[ch], {28'h0, ie});
    bus(1'b1, IDX_IIR[ch], {24'h0, tr, 3'h0, cl, fen});
    @(posedge pclk);
    // clear pulses stand for the one cycle after the write edge
    chk("fifo enable", {31'h0, fen_o[ch]}, {31'h0, fen});
    chk("trigger", {30'h0, trg[ch]}, {30'h0, tr});
    chk("clear rx", {31'h0, crx[ch]}, {31'h0, cl[1] & fen});
    chk("clear tx", {31'h0, ctx[ch]}, {31'h0, cl[0] & fen});
    pe[ch] <= e[0];
    fe[ch] <= e[1];
    ov[ch] <= e[2];
    bk[ch] <= e[3];
    rdy[ch] <= o[0];
    tmo[ch] <= o[1];
    txe[ch] <= o[2];
    mdm[ch] <= o[3];
    repeat (2) @(posedge pclk);
    bus(1'b0, IDX_IIR[ch], 32'h0);
    chk("ident", q, {24'h0, exp_id(fen, ie, {o, |e})});
  endtask : run
  initial
  begin
    void'($urandom(32'h4ec9_6ebc));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, IDX_IIR[1], 32'h0);
    chk("ident reset", q, 32'h0000_0001);
    bus(1'b0, IDX_IER[0], 32'h0);
    chk("enable reset", q, 32'h0000_0000);
    bus(1'b0, 8'h00, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h0000_0001);
    for (int k = 0; k < 5; k++)
      run(k % 2, k[0], 4'hf, {3'h0, k == 0}, 4'hf >> k - 1);
    for (int i = 0; i < 4; i++)
      run(i % 2, 1'b1, 4'h4, 4'h1 << i, 4'hf);
    repeat (40)
      run($urandom % 2, 1'($urandom), 4'($urandom),
        4'($urandom & $urandom & $urandom), 4'($urandom));
    run(0, 1'b0, 4'h0, 4'h0, 4'h0);
    run(1, 1'b0, 4'h2, 4'h0, 4'h0);
    bus(1'b1, IDX_STAT, 32'h0000_0003);
    bus(1'b1, IDX_MASK, 32'h0000_0002);
    run(1, 1'b0, 4'h2, 4'h0, 4'h4);
    repeat (3) @(posedge pclk);
    chk("irq set", {31'h0, irq}, 32'h0000_0001);
    bus(1'b0, IDX_STAT, 32'h0);
    chk("status", q, 32'h0000_0002);
    bus(1'b1, IDX_MASK, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    bus(1'b1, IDX_STAT, 32'h0000_0002);
    bus(1'b0, IDX_STAT, 32'h0);
    chk("status clr", q, 32'h0000_0000);
    tally_and_finish;
  end
endmodule : uiid_top_tb
